// ===== evt_timer_pkg.sv
// Notes on behaviour
// [R01] Event mode counts pin edges or overflow input
// [R02] Pin edge selectable: rising, falling, both
// [R03] Event mode counts down, reloads on underflow
// [R04] Set value n gives one underflow per n+1
// [R05] Start flag 1 runs, 0 halts counting
// [R06] Event mode underflow raises interrupt request
// [R07] Event mode count read returns live counter
// [R08] Write while stopped loads reload and counter
// [R09] Write while running loads reload only
// [R10] Pinless channel counts internal overflow only
// [R11] Measure mode counts up, captures, restarts
// [R12] Measure edge interrupt, except first after start
// [R13] Measure overflow sets flag and raises interrupt
// [R14] Mode write while started clears overflow flag
// [R15] Measure read gives capture, writes ignored
// [R16] Pinless channel has no measure mode
// [R17] Pin is pulse input or count source
// [R18] Mode chosen by mode register bits 1:0
// [R19] Pin synchronised before edge detection
package evt_timer_pkg;

  // Register byte offsets
  localparam logic [4:0] OFF_MODE   = 5'h00;
  localparam logic [4:0] OFF_COUNT  = 5'h04;
  localparam logic [4:0] OFF_START  = 5'h08;
  localparam logic [4:0] OFF_STATUS = 5'h0c;
  localparam logic [4:0] OFF_MASK   = 5'h10;

  // Mode register field positions
  localparam int MODE_SEL_LSB  = 0;
  localparam int EDGE_SEL_LSB  = 2;
  localparam int SRC_SEL_BIT   = 4;
  localparam int OVF_FLAG_BIT  = 5;
  localparam int CLK_SEL_LSB   = 6;

  // Status and mask bit positions
  localparam int ST_UNDERFLOW = 0;
  localparam int ST_EDGE      = 1;
  localparam int ST_OVERFLOW  = 2;

  // Reset values and counter maximum
  localparam logic [7:0]  MODE_RST  = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [2:0]  MASK_RST  = 3'h0;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  // Prescaler terminal counts
  localparam logic [2:0] DIV8_LAST  = 3'h7;
  localparam logic [4:0] DIV32_LAST = 5'h1f;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    md_timer, md_event, md_measure, md_reserved
  } mode_type;

  typedef enum logic [1:0] {
    edge_fall, edge_rise, edge_both, edge_both_alt
  } edge_type;

  typedef enum logic [1:0] {
    cs_div1, cs_div8, cs_div32, cs_sub32
  } clk_src_type;

  // Whole state of the channel
  typedef struct packed {
    logic [7:0]  mode;
    logic [15:0] count;
    logic [15:0] reload;
    logic        start;
    logic        ovf;
    logic        seen;
    logic [4:0]  psc;
    logic [4:0]  sub_psc;
    logic [2:0]  pin_sync;
    logic [2:0]  stat;
    logic [2:0]  mask;
    logic        irq;
    logic        aw_got;
    logic        aw_upper;
    logic [4:0]  aw_addr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_type;

  localparam state_type STATE_RST = '{
    mode:    MODE_RST,
    count:   COUNT_RST,
    reload:  COUNT_RST,
    mask:    MASK_RST,
    default: '0
  };

endpackage : evt_timer_pkg

// ===== evt_timer.sv
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
module evt_timer
  import evt_timer_pkg::*;
#(
  parameter int ADDR_W  = 8,
  parameter bit HAS_PIN = 1'b1
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              clk_en,
  input  wire logic              channel_event_input_pin,
  input  wire logic              timer_overflow_in,
  input  wire logic              subclock_tick,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   irq
);

  // Refuse address widths the decoder cannot serve
  if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 6 and 32");
  end

  state_type st;
  state_type next_st;

  mode_type    mode_e;
  edge_type    edge_e;
  clk_src_type src_e;
  logic        pin_rise;
  logic        pin_fall;
  logic        pin_edge;
  logic        int_tick;
  logic        ev_tick;
  logic        down_tick;
  logic        meas_on;
  logic        meas_edge;
  logic        meas_tick;
  logic        underflow;
  logic        wr_en;
  logic        wr_hit;
  logic        wr_mode;
  logic        wr_count;
  logic [31:0] wr_mask;
  logic [31:0] rd_val;
  logic        rd_hit;
  logic        wr_status;

  // Address decode shared by both channels
  function automatic logic addr_hit(input logic upper_zero,
                                    input logic [4:0] a);
    addr_hit = upper_zero &&
      (a == OFF_MODE || a == OFF_COUNT || a == OFF_START ||
       a == OFF_STATUS || a == OFF_MASK);
  endfunction : addr_hit

  // Read multiplexer over the live state
  function automatic logic [31:0] read_reg(input state_type s,
                                           input logic [4:0] a);
    logic [7:0] m;
    m = s.mode;
    m[OVF_FLAG_BIT] = s.ovf;
    read_reg = 32'h0000_0000;
    case (a)
      OFF_MODE:   read_reg = {24'h00_0000, m};
      OFF_COUNT:  begin
        if (mode_type'(s.mode[MODE_SEL_LSB +: 2]) == md_measure) begin
          read_reg = {16'h0000, s.reload}; // R15
        end else begin
          read_reg = {16'h0000, s.count}; // R07
        end
      end
      OFF_START:  read_reg = {31'h0000_0000, s.start};
      OFF_STATUS: read_reg = {29'h0000_0000, s.stat};
      OFF_MASK:   read_reg = {29'h0000_0000, s.mask};
      default:    read_reg = 32'h0000_0000;
    endcase
  endfunction : read_reg

  // Mode fields and edge detection
  always_comb begin
    mode_e   = mode_type'(st.mode[MODE_SEL_LSB +: 2]); // R18
    edge_e   = edge_type'(st.mode[EDGE_SEL_LSB +: 2]);
    src_e    = clk_src_type'(st.mode[CLK_SEL_LSB +: 2]);
    // Stages 1 and 2 compared, stage 0 only feeds stage 1
    pin_rise = st.pin_sync[1] && !st.pin_sync[2]; // R19
    pin_fall = !st.pin_sync[1] && st.pin_sync[2]; // R19
    case (edge_e) // R02
      edge_fall: pin_edge = pin_fall;
      edge_rise: pin_edge = pin_rise;
      default:   pin_edge = pin_rise || pin_fall;
    endcase
    case (src_e) // R11
      cs_div1:  int_tick = 1'b1;
      cs_div8:  int_tick = st.psc[2:0] == DIV8_LAST;
      cs_div32: int_tick = st.psc == DIV32_LAST;
      default:  int_tick = subclock_tick && st.sub_psc == DIV32_LAST;
    endcase
  end

  // Count events per mode
  always_comb begin
    // Pin or overflow source; pinless channel uses overflow only
    if (HAS_PIN && !st.mode[SRC_SEL_BIT]) begin // R10
      ev_tick = pin_edge; // R17
    end else begin
      ev_tick = timer_overflow_in; // R01
    end
    case (mode_e)
      md_timer: down_tick = st.start && int_tick;
      md_event: down_tick = st.start && ev_tick; // R05
      default:  down_tick = 1'b0;
    endcase
    meas_on   = HAS_PIN && st.start && mode_e == md_measure; // R16
    meas_edge = meas_on && pin_edge; // R17
    meas_tick = meas_on && int_tick;
    underflow = down_tick && st.count == COUNT_RST;
  end

  // Bus write strobes
  always_comb begin
    wr_en    = st.aw_got && st.w_got && !st.bvalid;
    wr_hit   = addr_hit(st.aw_upper, st.aw_addr);
    wr_mode  = wr_en && wr_hit && st.aw_addr == OFF_MODE;
    wr_count = wr_en && wr_hit && st.aw_addr == OFF_COUNT;
    wr_status = wr_en && wr_hit && st.aw_addr == OFF_STATUS;
    for (int b = 0; b < 4; b++) begin
      wr_mask[8*b +: 8] = {8{st.wstrb[b]}};
    end
    rd_hit = addr_hit(araddr[ADDR_W-1:5] == '0, araddr[4:0]);
    rd_val = read_reg(st, araddr[4:0]);
  end

  // Next state of the whole channel
  always_comb begin
    logic [31:0] merged;
    merged = 32'h0000_0000;
    next_st = st;

    // Input synchroniser and prescalers
    next_st.pin_sync = {st.pin_sync[1:0], channel_event_input_pin}; // R19
    next_st.psc = st.psc + 5'h01;
    if (subclock_tick) begin
      next_st.sub_psc = st.sub_psc + 5'h01;
    end

    // Down counting with reload of n gives n+1 events per underflow
    if (underflow) begin
      next_st.count = st.reload; // R03 R04
      next_st.stat[ST_UNDERFLOW] = 1'b1; // R06
    end else if (down_tick) begin
      next_st.count = st.count - 16'h0001; // R03
    end

    // Up counting with capture at each effective edge
    if (meas_edge) begin
      next_st.reload = st.count; // R11
      next_st.count  = COUNT_RST; // R11
      next_st.seen   = 1'b1;
    end else if (meas_tick) begin
      next_st.count = st.count + 16'h0001; // R11
    end

    // Register writes
    if (wr_en) begin
      merged = (read_reg(st, st.aw_addr) & ~wr_mask) |
               (st.wdata & wr_mask);
      if (wr_mode) begin
        next_st.mode = merged[7:0];
        if (st.start) begin
          next_st.ovf = 1'b0; // R14
        end
      end
      if (wr_count && mode_e != md_measure) begin // R15
        next_st.reload = merged[15:0]; // R09
        if (!st.start) begin
          next_st.count = merged[15:0]; // R08
        end
      end
      if (wr_hit && st.aw_addr == OFF_START) begin
        next_st.start = merged[0]; // R05
        if (merged[0] && !st.start) begin
          next_st.seen = 1'b0; // R12
        end
      end
      // Only strobed ones clear; unstrobed lanes keep their flags
      if (wr_status) begin
        next_st.stat = st.stat & ~(st.wdata[2:0] & wr_mask[2:0]); // R06
      end
      if (wr_hit && st.aw_addr == OFF_MASK) begin
        next_st.mask = merged[2:0];
      end
    end

    // Events set after the clear so they win
    if (underflow) begin
      next_st.stat[ST_UNDERFLOW] = 1'b1;
    end
    if (meas_edge && st.seen) begin
      next_st.stat[ST_EDGE] = 1'b1; // R12
    end
    if (meas_tick && !meas_edge && st.count == COUNT_MAX) begin
      next_st.ovf = 1'b1; // R13
      next_st.stat[ST_OVERFLOW] = 1'b1; // R13
    end
    next_st.irq = |(next_st.stat & next_st.mask);

    // Write address and data, either order
    if (awvalid && st.awready) begin
      next_st.aw_got   = 1'b1;
      next_st.aw_addr  = awaddr[4:0];
      next_st.aw_upper = awaddr[ADDR_W-1:5] == '0;
    end
    if (wvalid && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = wdata;
      next_st.wstrb = wstrb;
    end
    if (wr_en) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready  = !next_st.w_got && !next_st.bvalid;

    // Read channel, one answer at a time
    if (arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_hit ? rd_val : 32'h0000_0000;
      next_st.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    next_st.arready = !next_st.rvalid;
  end

  // State register, frozen while clock enable is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= STATE_RST;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign awready = st.awready;
  assign wready  = st.wready;
  assign bvalid  = st.bvalid;
  assign bresp   = st.bresp;
  assign arready = st.arready;
  assign rvalid  = st.rvalid;
  assign rdata   = st.rdata;
  assign rresp   = st.rresp;
  assign irq     = st.irq;

  // Checks on enabled clock edges
  default clocking cb @(posedge aclk iff clk_en);
  endclocking
  default disable iff (!aresetn);

  sequence s_event_dec;
    mode_e == md_event && down_tick && !underflow && !wr_count;
  endsequence

  sequence s_event_uf;
    mode_e == md_event && underflow && !wr_count;
  endsequence

  sequence s_meas_first;
    meas_edge && !st.seen && !st.stat[ST_EDGE];
  endsequence

  a_event_decrement: assert property ( // R03
    s_event_dec |=> st.count == $past(st.count) - 16'h0001)
    else $error("event count did not decrement");

  a_underflow_reload: assert property ( // R04
    s_event_uf |=> st.count == $past(st.reload) &&
                   st.stat[ST_UNDERFLOW])
    else $error("underflow did not reload or flag");

  a_stopped_hold: assert property ( // R05
    !st.start && !wr_count |=> $stable(st.count))
    else $error("counter moved while stopped");

  a_stopped_write: assert property ( // R08
    mode_e == md_event && !st.start && wr_count &&
    st.wstrb == 4'hf
    |=> st.count == st.reload &&
        st.count == $past(st.wdata[15:0]))
    else $error("stopped write missed counter");

  a_running_write: assert property ( // R09
    mode_e == md_event && st.start && wr_count && !down_tick
    |=> $stable(st.count))
    else $error("running write touched counter");

  a_meas_capture: assert property ( // R11
    meas_edge |=> st.count == COUNT_RST &&
                  st.reload == $past(st.count))
    else $error("capture or restart wrong");

  a_first_edge_quiet: assert property ( // R12
    s_meas_first |=> !st.stat[ST_EDGE])
    else $error("first edge raised a request");

  a_overflow_flag: assert property ( // R13
    meas_tick && !meas_edge && st.count == COUNT_MAX
    |=> st.ovf && st.stat[ST_OVERFLOW] && st.count == COUNT_RST)
    else $error("overflow not flagged");

  a_overflow_clear: assert property ( // R14
    wr_mode && st.start && !meas_tick |=> !st.ovf)
    else $error("mode write kept overflow flag");

  a_meas_no_write: assert property ( // R15
    mode_e == md_measure && wr_count && !meas_edge
    |=> $stable(st.reload))
    else $error("measure write changed capture");

  a_irq_level: assert property ( // R06
    st.irq == |(st.stat & st.mask))
    else $error("interrupt level mismatch");

  a_edge_request: assert property ( // R12
    meas_edge && st.seen |=> st.stat[ST_EDGE])
    else $error("later edge raised no request");

  a_status_sticky: assert property ( // R06
    st.stat[ST_UNDERFLOW] && !wr_status |=> st.stat[ST_UNDERFLOW])
    else $error("underflow flag lost");

  a_overflow_source: assert property ( // R01
    mode_e == md_event && st.mode[SRC_SEL_BIT] &&
    !timer_overflow_in |-> !down_tick)
    else $error("counted without overflow input");

  a_stopped_capture: assert property ( // R05
    mode_e == md_measure && !st.start |=> $stable(st.reload))
    else $error("capture while stopped");

  a_event_read: assert property ( // R07
    arvalid && st.arready && rd_hit && araddr[4:0] == OFF_COUNT &&
    mode_e == md_event |=> st.rdata == {16'h0000, $past(st.count)})
    else $error("count read not live value");

  a_meas_up_count: assert property ( // R11
    meas_tick && !meas_edge && st.count != COUNT_MAX
    |=> st.count == $past(st.count) + 16'h0001)
    else $error("measure count did not step up");

  a_start_write: assert property ( // R05
    wr_en && wr_hit && st.aw_addr == OFF_START && st.wstrb[0]
    |=> st.start == $past(st.wdata[0]))
    else $error("start flag write lost");

endmodule : evt_timer

// ===== event_pulse_source.sv
`timescale 1ns/1ns
module event_pulse_source (
  input  wire logic aclk,
  output logic      pin
);
  // Idle low between pulses
  initial pin = 1'b0;

  // Whole pulses, high for gap cycles, low for gap+1 cycles between pulses
  task automatic pulses(input int n, input int gap);
    repeat (n) begin
      @(posedge aclk);
      pin <= 1'b1;
      repeat (gap) @(posedge aclk);
      pin <= 1'b0;
      repeat (gap) @(posedge aclk);
    end
  endtask : pulses
endmodule : event_pulse_source

// ===== test_event_count_pulse_measure_timer.sv
`timescale 1ns/1ns
module test_event_count_pulse_measure_timer
  import evt_timer_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        pin;
  logic        tovf = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata, rd_v;
  int          miscompares = 0;
  int          checks = 0;
  int          k, n, g, mcnt, mrel;
  int          per, f;
  longint      rise_t = 0;
  logic        ce = 1'b1;

  // 125 MHz clock
  always #4 aclk = ~aclk;

  event_pulse_source u_src (.aclk(aclk), .pin(pin));

  evt_timer u_dut (
    .aclk(aclk), .aresetn(aresetn), .clk_en(ce),
    .channel_event_input_pin(pin), .timer_overflow_in(tovf),
    .subclock_tick(1'b0), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .irq(irq)
  );

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  // Bus write, both channels offered together
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= {3'h0, a};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp    = bresp;
    bready <= 1'b0;
  endtask : wr

  // Bus read
  task automatic rd(input logic [4:0] a);
    @(posedge aclk);
    araddr  <= {3'h0, a};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_v   = rdata;
    rsp    = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    rd(a);
    check(rd_v, exp);
  endtask : rdc

  // Model of the down counter over k events
  task automatic mev(input int e);
    repeat (e) begin
      if (mcnt == 0) mcnt = mrel;
      else mcnt--;
    end
  endtask : mev

  // Cycles between the last two rising pin edges
  always @(posedge pin) begin
    per    = int'(($time - rise_t) / 8);
    rise_t = $time;
  end

  // Hang guard
  initial begin
    repeat (95000) @(posedge aclk);
    miscompares++;
    end_sim();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h2a6d6fea));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(OFF_MODE, 32'h0);
    rdc(OFF_COUNT, 32'h0);
    rdc(OFF_START, 32'h0);
    rdc(OFF_STATUS, 32'h0);
    rdc(OFF_MASK, 32'h0);
    rd(5'h14);
    check(rsp, RESP_SLVERR);
    $display("test reset done");
    // Falling, rising, both edges; stop halts counting
    for (int e = 0; e < 3; e++) begin
      wr(OFF_START, 32'h0);
      wr(OFF_COUNT, 32'h20);
      mcnt = 32;
      mrel = 32;
      wr(OFF_MODE, {28'h0, e[1:0], 2'b01});
      wr(OFF_START, 32'h1);
      k = $urandom_range(6, 2);
      u_src.pulses(k, 5);
      mev(e == 2 ? 2 * k : k);
      rdc(OFF_COUNT, mcnt);
      wr(OFF_START, 32'h0);
      u_src.pulses(1, 5);
      rdc(OFF_COUNT, mcnt);
    end
    $display("test edges done");
    // Underflow, reload, divide ratio, interrupt
    n = $urandom_range(4, 1);
    wr(OFF_COUNT, n);
    wr(OFF_MODE, 32'h05);
    wr(OFF_MASK, 32'h1);
    wr(OFF_START, 32'h1);
    u_src.pulses(n, 5);
    rdc(OFF_COUNT, 32'h0);
    check(irq, 1'b0);
    u_src.pulses(1, 5);
    rdc(OFF_COUNT, n);
    rdc(OFF_STATUS, 32'h1);
    check(irq, 1'b1);
    wr(OFF_MASK, 32'h0);
    check(irq, 1'b0);
    wr(OFF_MASK, 32'h1);
    wr(OFF_STATUS, 32'h1);
    check(irq, 1'b0);
    wr(OFF_COUNT, n + 2);
    rdc(OFF_COUNT, n);
    u_src.pulses(n + 1, 5);
    rdc(OFF_COUNT, n + 2);
    $display("test underflow done");
    // Other timer overflow as source, pin ignored
    wr(OFF_START, 32'h0);
    wr(OFF_COUNT, 32'h10);
    wr(OFF_MODE, 32'h15);
    wr(OFF_START, 32'h1);
    k = $urandom_range(5, 1);
    repeat (k) begin
      @(posedge aclk);
      tovf <= 1'b1;
      @(posedge aclk);
      tovf <= 1'b0;
      repeat (3) @(posedge aclk);
    end
    u_src.pulses(2, 5);
    rdc(OFF_COUNT, 32'h10 - k);
    $display("test source done");
    // Period measurement with capture
    wr(OFF_START, 32'h0);
    wr(OFF_MODE, 32'h06);
    wr(OFF_STATUS, 32'h7);
    wr(OFF_MASK, 32'h2);
    wr(OFF_START, 32'h1);
    g = $urandom_range(20, 8);
    u_src.pulses(1, g);
    rdc(OFF_STATUS, 32'h0);
    // Frozen cycles count nothing
    f = $urandom_range(9, 3);
    ce <= 1'b0;
    repeat (f) @(posedge aclk);
    ce <= 1'b1;
    u_src.pulses(1, g);
    rdc(OFF_STATUS, 32'h2);
    check(irq, 1'b1);
    rd(OFF_COUNT);
    check(rd_v, per - 1 - f);
    k = rd_v;
    wr(OFF_COUNT, 32'h1234);
    rdc(OFF_COUNT, k);
    $display("test measure done");
    // Overflow flag and its clearing by a mode write
    wr(OFF_START, 32'h0);
    wr(OFF_STATUS, 32'h7);
    wr(OFF_START, 32'h1);
    repeat (65600) @(posedge aclk);
    rdc(OFF_STATUS, 32'h4);
    rdc(OFF_MODE, 32'h26);
    wr(OFF_MODE, 32'h06);
    rdc(OFF_MODE, 32'h06);
    $display("test overflow done");
    // Eighth-rate count source
    wr(OFF_START, 32'h0);
    wr(OFF_MODE, 32'h46);
    wr(OFF_START, 32'h1);
    u_src.pulses(2, g);
    rd(OFF_COUNT);
    check(rd_v >= (per - 1) / 8 && rd_v <= (per + 6) / 8, 1'b1);
    $display("test prescale done");
    end_sim();
  end
endmodule : test_event_count_pulse_measure_timer
